// ---- xbo_pkg.sv ----
// Shared constants and types for the exchange/block/branch executor
package xbo_pkg;
  localparam int          FLAG_ZERO_POS  = 6;
  localparam int          FLAG_CARRY_POS = 0;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic [15:0] STACK_RESET    = 16'hffff;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [1:0]  MODE_RESET     = 2'h0;
  localparam logic [1:0]  COND_NONZERO   = 2'h0;
  localparam logic [1:0]  COND_ZERO      = 2'h1;
  localparam logic [1:0]  COND_NOCARRY   = 2'h2;
  localparam logic [1:0]  COND_CARRY     = 2'h3;
  localparam logic [1:0]  PAIR_COUNTER   = 2'h0;
  localparam logic [1:0]  PAIR_TARGET    = 2'h1;
  localparam logic [1:0]  PAIR_MEMPTR    = 2'h2;
  localparam logic [1:0]  PAIR_STACK     = 2'h3;
  localparam logic [1:0]  SS_MEMPTR      = 2'h0;
  localparam logic [1:0]  SS_INDEX_X     = 2'h1;
  localparam logic [2:0]  RSEL_ACC       = 3'h7;

  typedef enum logic [4:0] {
    OP_IDLE, OP_INT_DISABLE, OP_INT_ENABLE, OP_SWAP_STACK, OP_SWAP_ACCF,
    OP_SWAP_TGT_MPTR, OP_SWAP_ALL, OP_HALT, OP_MODE0, OP_MODE1, OP_MODE2,
    OP_IN_IMM, OP_IN_REG, OP_BIN_UP_STEP, OP_BIN_DOWN_STEP,
    OP_BIN_UP_REPEAT, OP_BIN_DOWN_REPEAT, OP_ABS_BRANCH, OP_ABS_BRANCH_SS,
    OP_REL_BRANCH, OP_LD_ACC_IVEC, OP_LD_ACC_RFSH, OP_LD_IVEC_ACC,
    OP_LD_RFSH_ACC, OP_LD_STK_SS, OP_LD_PAIR_MEM, OP_ST_PAIR_MEM,
    OP_MOVE_UP_STEP, OP_MOVE_DOWN_STEP, OP_MOVE_UP_REPEAT,
    OP_MOVE_DOWN_REPEAT, OP_TWOS_COMPLEMENT
  } xbo_op_type;

  typedef struct packed {
    xbo_op_type  op;
    logic [2:0]  rsel;
    logic [1:0]  pair;
    logic [1:0]  ss;
    logic        cond_en;
    logic [1:0]  cond;
    logic [1:0]  len;
    logic [15:0] imm;
  } xbo_cmd_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] tgt;
    logic [15:0] mptr;
    logic [15:0] cnt_alt;
    logic [15:0] tgt_alt;
    logic [15:0] mptr_alt;
    logic [7:0]  acc;
    logic [7:0]  flg;
    logic [7:0]  acc_alt;
    logic [7:0]  flg_alt;
    logic [15:0] pcnt;
    logic [15:0] stk;
    logic [15:0] idx_x;
    logic [15:0] idx_y;
    logic [7:0]  ivec;
    logic [7:0]  rfsh;
    logic [1:0]  imode;
    logic        ien;
  } xbo_regs_type;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic        io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } xbo_bus_type;
endpackage

// ---- xbo_exec.sv ----
// Executor for exchange, halt, mode, input, branch, load and block ops
`timescale 1ns/1ps
module xbo_exec (
  input  wire logic              sys_clk_i,   // 20 MHz clock
  input  wire logic              sys_rst_i,   // Sync reset, high
  input  wire logic              cmd_valid_i, // Decoded op offered
  input  wire xbo_pkg::xbo_cmd_type cmd_i,    // Decoded op
  output logic                   cmd_ready_o, // Ready for an op
  input  wire logic              irq_i,       // Interrupt pin
  output logic                   mem_req_o,   // Bus request
  output logic                   mem_wr_o,    // Write when high
  output logic                   mem_io_o,    // Port space when high
  output logic [15:0]            mem_addr_o,  // Bus address
  output logic [7:0]             mem_wdata_o, // Write data
  input  wire logic              mem_ack_i,   // Bus cycle done
  input  wire logic [7:0]        mem_rdata_i, // Read data on ack
  output logic                   halted_o,    // Halt state
  output logic [15:0]            pcnt_o,      // Program counter
  output logic [7:0]             acc_o,       // Accumulator
  output logic [1:0]             imode_o      // Interrupt mode
);
  typedef enum logic [3:0] {
    S_IDLE, S_RD0, S_RD1, S_WR0, S_WR1, S_IOR, S_MRD, S_BWR, S_HALT
  } xbo_state_type;

  xbo_state_type         st_q, st_d;
  xbo_pkg::xbo_regs_type rg_q, rg_d;
  xbo_pkg::xbo_bus_type  bus_q, bus_d;
  xbo_pkg::xbo_cmd_type  cmd_q, cmd_d;
  logic [15:0]           tmp_q, tmp_d;
  logic                  irq_s1_q, irq_s2_q;
  logic                  take;

  function automatic xbo_pkg::xbo_bus_type bus_req(
    input logic wr, input logic io, input logic [15:0] a,
    input logic [7:0] wd);
    bus_req = '{req: 1'b1, wr: wr, io: io, addr: a, wdata: wd};
  endfunction

  function automatic logic [15:0] get_rr(xbo_pkg::xbo_regs_type r,
                                         logic [1:0] s);
    case (s)
      xbo_pkg::PAIR_COUNTER: get_rr = r.cnt;
      xbo_pkg::PAIR_TARGET:  get_rr = r.tgt;
      xbo_pkg::PAIR_MEMPTR:  get_rr = r.mptr;
      default:               get_rr = r.stk;
    endcase
  endfunction

  function automatic xbo_pkg::xbo_regs_type set_rr(
    xbo_pkg::xbo_regs_type r, logic [1:0] s, logic [15:0] v);
    set_rr = r;
    case (s)
      xbo_pkg::PAIR_COUNTER: set_rr.cnt = v;
      xbo_pkg::PAIR_TARGET:  set_rr.tgt = v;
      xbo_pkg::PAIR_MEMPTR:  set_rr.mptr = v;
      default:               set_rr.stk = v;
    endcase
  endfunction

  function automatic logic [15:0] get_ss(xbo_pkg::xbo_regs_type r,
                                         logic [1:0] s);
    case (s)
      xbo_pkg::SS_MEMPTR:  get_ss = r.mptr;
      xbo_pkg::SS_INDEX_X: get_ss = r.idx_x;
      default:             get_ss = r.idx_y;
    endcase
  endfunction

  function automatic xbo_pkg::xbo_regs_type set_ss(
    xbo_pkg::xbo_regs_type r, logic [1:0] s, logic [15:0] v);
    set_ss = r;
    case (s)
      xbo_pkg::SS_MEMPTR:  set_ss.mptr = v;
      xbo_pkg::SS_INDEX_X: set_ss.idx_x = v;
      default:             set_ss.idx_y = v;
    endcase
  endfunction

  // Select code 6 has no target; the byte is dropped
  function automatic xbo_pkg::xbo_regs_type set_r8(
    xbo_pkg::xbo_regs_type r, logic [2:0] s, logic [7:0] v);
    set_r8 = r;
    case (s)
      3'h0:    set_r8.cnt[15:8] = v;
      3'h1:    set_r8.cnt[7:0] = v;
      3'h2:    set_r8.tgt[15:8] = v;
      3'h3:    set_r8.tgt[7:0] = v;
      3'h4:    set_r8.mptr[15:8] = v;
      3'h5:    set_r8.mptr[7:0] = v;
      3'h7:    set_r8.acc = v;
      default: set_r8 = r;
    endcase
  endfunction

  function automatic logic cond_ok(logic [7:0] f, logic en, logic [1:0] c);
    case (c)
      xbo_pkg::COND_NONZERO: cond_ok = !en || !f[xbo_pkg::FLAG_ZERO_POS];
      xbo_pkg::COND_ZERO:    cond_ok = !en || f[xbo_pkg::FLAG_ZERO_POS];
      xbo_pkg::COND_NOCARRY: cond_ok = !en || !f[xbo_pkg::FLAG_CARRY_POS];
      default:               cond_ok = !en || f[xbo_pkg::FLAG_CARRY_POS];
    endcase
  endfunction

  function automatic logic is_move(xbo_pkg::xbo_op_type o);
    is_move = o inside {xbo_pkg::OP_MOVE_UP_STEP, xbo_pkg::OP_MOVE_DOWN_STEP,
                        xbo_pkg::OP_MOVE_UP_REPEAT,
                        xbo_pkg::OP_MOVE_DOWN_REPEAT};
  endfunction

  function automatic logic is_up(xbo_pkg::xbo_op_type o);
    is_up = o inside {xbo_pkg::OP_MOVE_UP_STEP, xbo_pkg::OP_MOVE_UP_REPEAT,
                      xbo_pkg::OP_BIN_UP_STEP, xbo_pkg::OP_BIN_UP_REPEAT};
  endfunction

  function automatic logic is_rep(xbo_pkg::xbo_op_type o);
    is_rep = o inside {xbo_pkg::OP_MOVE_UP_REPEAT,
                       xbo_pkg::OP_MOVE_DOWN_REPEAT,
                       xbo_pkg::OP_BIN_UP_REPEAT,
                       xbo_pkg::OP_BIN_DOWN_REPEAT};
  endfunction

  assign take = (st_q == S_IDLE) && cmd_valid_i;

  always_comb begin
    logic [15:0] stp;
    logic        more;
    stp   = 16'h0000;
    more  = 1'b0;
    st_d  = st_q;
    rg_d  = rg_q;
    bus_d = bus_q;
    cmd_d = cmd_q;
    tmp_d = tmp_q;
    case (st_q)
      S_IDLE: if (cmd_valid_i) begin
        cmd_d = cmd_i;
        rg_d.pcnt = rg_q.pcnt + 16'(cmd_i.len);
        case (cmd_i.op)
          xbo_pkg::OP_INT_DISABLE: rg_d.ien = 1'b0;
          xbo_pkg::OP_INT_ENABLE:  rg_d.ien = 1'b1;
          xbo_pkg::OP_SWAP_STACK: begin
            st_d  = S_RD0;
            bus_d = bus_req(1'b0, 1'b0, rg_q.stk, 8'h00);
          end
          xbo_pkg::OP_SWAP_ACCF: begin
            {rg_d.acc, rg_d.flg} = {rg_q.acc_alt, rg_q.flg_alt};
            {rg_d.acc_alt, rg_d.flg_alt} = {rg_q.acc, rg_q.flg};
          end
          xbo_pkg::OP_SWAP_TGT_MPTR: begin
            rg_d.tgt  = rg_q.mptr;
            rg_d.mptr = rg_q.tgt;
          end
          xbo_pkg::OP_SWAP_ALL: begin
            {rg_d.cnt, rg_d.cnt_alt}   = {rg_q.cnt_alt, rg_q.cnt};
            {rg_d.tgt, rg_d.tgt_alt}   = {rg_q.tgt_alt, rg_q.tgt};
            {rg_d.mptr, rg_d.mptr_alt} = {rg_q.mptr_alt, rg_q.mptr};
          end
          xbo_pkg::OP_HALT:  st_d = S_HALT;
          xbo_pkg::OP_MODE0: rg_d.imode = 2'h0;
          xbo_pkg::OP_MODE1: rg_d.imode = 2'h1;
          xbo_pkg::OP_MODE2: rg_d.imode = 2'h2;
          xbo_pkg::OP_IN_IMM: begin
            st_d  = S_IOR;
            bus_d = bus_req(1'b0, 1'b1, {rg_q.acc, cmd_i.imm[7:0]}, 8'h00);
          end
          xbo_pkg::OP_IN_REG, xbo_pkg::OP_BIN_UP_STEP,
          xbo_pkg::OP_BIN_DOWN_STEP, xbo_pkg::OP_BIN_UP_REPEAT,
          xbo_pkg::OP_BIN_DOWN_REPEAT: begin
            st_d  = S_IOR;
            bus_d = bus_req(1'b0, 1'b1, rg_q.cnt, 8'h00);
          end
          xbo_pkg::OP_ABS_BRANCH:
            if (cond_ok(rg_q.flg, cmd_i.cond_en, cmd_i.cond))
              rg_d.pcnt = cmd_i.imm;
          xbo_pkg::OP_ABS_BRANCH_SS: rg_d.pcnt = get_ss(rg_q, cmd_i.ss);
          xbo_pkg::OP_REL_BRANCH:
            if (cond_ok(rg_q.flg, cmd_i.cond_en, cmd_i.cond))
              rg_d.pcnt = rg_q.pcnt + 16'(cmd_i.len)
                          + {{8{cmd_i.imm[7]}}, cmd_i.imm[7:0]};
          xbo_pkg::OP_LD_ACC_IVEC: rg_d.acc  = rg_q.ivec;
          xbo_pkg::OP_LD_ACC_RFSH: rg_d.acc  = rg_q.rfsh;
          xbo_pkg::OP_LD_IVEC_ACC: rg_d.ivec = rg_q.acc;
          xbo_pkg::OP_LD_RFSH_ACC: rg_d.rfsh = rg_q.acc;
          xbo_pkg::OP_LD_STK_SS: rg_d.stk = get_ss(rg_q, cmd_i.ss);
          xbo_pkg::OP_LD_PAIR_MEM: begin
            st_d  = S_RD0;
            bus_d = bus_req(1'b0, 1'b0, cmd_i.imm, 8'h00);
          end
          xbo_pkg::OP_ST_PAIR_MEM: begin
            st_d  = S_WR0;
            bus_d = bus_req(1'b1, 1'b0, cmd_i.imm,
                            8'(get_rr(rg_q, cmd_i.pair)));
          end
          xbo_pkg::OP_MOVE_UP_STEP, xbo_pkg::OP_MOVE_DOWN_STEP,
          xbo_pkg::OP_MOVE_UP_REPEAT,
          xbo_pkg::OP_MOVE_DOWN_REPEAT: begin
            st_d  = S_MRD;
            bus_d = bus_req(1'b0, 1'b0, rg_q.mptr, 8'h00);
          end
          xbo_pkg::OP_TWOS_COMPLEMENT: rg_d.acc = 8'h00 - rg_q.acc;
          default: rg_d.pcnt = rg_q.pcnt + 16'(cmd_i.len);
        endcase
      end
      S_RD0: if (mem_ack_i) begin
        tmp_d[7:0] = mem_rdata_i;
        st_d       = S_RD1;
        bus_d      = bus_req(1'b0, 1'b0, bus_q.addr + 16'h0001, 8'h00);
      end
      S_RD1: if (mem_ack_i) begin
        tmp_d[15:8] = mem_rdata_i;
        if (cmd_q.op == xbo_pkg::OP_SWAP_STACK) begin
          st_d  = S_WR0;
          bus_d = bus_req(1'b1, 1'b0, rg_q.stk,
                          8'(get_ss(rg_q, cmd_q.ss)));
        end else begin
          rg_d  = set_rr(rg_q, cmd_q.pair, {mem_rdata_i, tmp_q[7:0]});
          st_d  = S_IDLE;
          bus_d = '0;
        end
      end
      S_WR0: if (mem_ack_i) begin
        st_d  = S_WR1;
        bus_d = bus_req(1'b1, 1'b0, bus_q.addr + 16'h0001,
                        (cmd_q.op == xbo_pkg::OP_SWAP_STACK)
                        ? 8'(get_ss(rg_q, cmd_q.ss) >> 8)
                        : 8'(get_rr(rg_q, cmd_q.pair) >> 8));
      end
      S_WR1: if (mem_ack_i) begin
        if (cmd_q.op == xbo_pkg::OP_SWAP_STACK)
          rg_d = set_ss(rg_q, cmd_q.ss, tmp_q);
        st_d  = S_IDLE;
        bus_d = '0;
      end
      S_IOR: if (mem_ack_i) begin
        if (cmd_q.op == xbo_pkg::OP_IN_IMM) begin
          rg_d  = set_r8(rg_q, xbo_pkg::RSEL_ACC, mem_rdata_i);
          st_d  = S_IDLE;
          bus_d = '0;
        end else if (cmd_q.op == xbo_pkg::OP_IN_REG) begin
          rg_d  = set_r8(rg_q, cmd_q.rsel, mem_rdata_i);
          st_d  = S_IDLE;
          bus_d = '0;
        end else begin
          st_d  = S_BWR;
          bus_d = bus_req(1'b1, 1'b0, rg_q.mptr, mem_rdata_i);
        end
      end
      S_MRD: if (mem_ack_i) begin
        st_d  = S_BWR;
        bus_d = bus_req(1'b1, 1'b0, rg_q.tgt, mem_rdata_i);
      end
      S_BWR: if (mem_ack_i) begin
        stp       = is_up(cmd_q.op) ? 16'h0001 : 16'hffff;
        rg_d.mptr = rg_q.mptr + stp;
        if (is_move(cmd_q.op)) begin
          rg_d.tgt = rg_q.tgt + stp;
          rg_d.cnt = rg_q.cnt - 16'h0001;
          more     = (rg_d.cnt != 16'h0000);
        end else begin
          rg_d.cnt[15:8] = rg_q.cnt[15:8] - 8'h01;
          more           = (rg_d.cnt[15:8] != 8'h00);
        end
        if (is_rep(cmd_q.op) && more) begin
          st_d  = is_move(cmd_q.op) ? S_MRD : S_IOR;
          bus_d = is_move(cmd_q.op)
                  ? bus_req(1'b0, 1'b0, rg_d.mptr, 8'h00)
                  : bus_req(1'b0, 1'b1, rg_d.cnt, 8'h00);
        end else begin
          st_d  = S_IDLE;
          bus_d = '0;
        end
      end
      S_HALT: if (irq_s2_q) st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st_q     <= S_IDLE;
      rg_q     <= '0;
      rg_q.stk <= xbo_pkg::STACK_RESET;
      rg_q.imode <= xbo_pkg::MODE_RESET;
      bus_q    <= '0;
      cmd_q    <= '0;
      tmp_q    <= xbo_pkg::PTR_RESET;
      irq_s1_q <= 1'b0;
      irq_s2_q <= 1'b0;
      cmd_ready_o <= 1'b0;
      halted_o <= 1'b0;
    end else begin
      st_q     <= st_d;
      rg_q     <= rg_d;
      bus_q    <= bus_d;
      cmd_q    <= cmd_d;
      tmp_q    <= tmp_d;
      irq_s1_q <= irq_i;
      irq_s2_q <= irq_s1_q;
      cmd_ready_o <= (st_d == S_IDLE);
      halted_o <= (st_d == S_HALT);
    end
  end

  assign mem_req_o   = bus_q.req;
  assign mem_wr_o    = bus_q.wr;
  assign mem_io_o    = bus_q.io;
  assign mem_addr_o  = bus_q.addr;
  assign mem_wdata_o = bus_q.wdata;
  assign pcnt_o      = rg_q.pcnt;
  assign acc_o       = rg_q.acc;
  assign imode_o     = rg_q.imode;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  swap_acc_a: assert property (take && cmd_i.op == xbo_pkg::OP_SWAP_ACCF
    |=> acc_o == $past(rg_q.acc_alt) && rg_q.acc_alt == $past(rg_q.acc))
    else $error("accumulator swap wrong");
  swap_ptr_a: assert property (take && cmd_i.op == xbo_pkg::OP_SWAP_TGT_MPTR
    |=> rg_q.tgt == $past(rg_q.mptr) && rg_q.mptr == $past(rg_q.tgt))
    else $error("pointer swap wrong");
  swap_all_a: assert property (take && cmd_i.op == xbo_pkg::OP_SWAP_ALL
    |=> rg_q.cnt == $past(rg_q.cnt_alt) && rg_q.tgt_alt == $past(rg_q.tgt))
    else $error("shadow swap wrong");
  halt_hold_a: assert property (halted_o && !irq_s2_q
    |=> halted_o && $stable(pcnt_o))
    else $error("halt left early");
  mode_two_a: assert property (take && cmd_i.op == xbo_pkg::OP_MODE2
    |=> imode_o == 2'h2) else $error("mode 2 not set");
  port_imm_a: assert property (take && cmd_i.op == xbo_pkg::OP_IN_IMM
    |=> mem_req_o && mem_io_o && mem_addr_o[7:0] == $past(cmd_i.imm[7:0]))
    else $error("port address wrong");
  stack_read_a: assert property (take && cmd_i.op == xbo_pkg::OP_SWAP_STACK
    |=> mem_req_o && !mem_wr_o && mem_addr_o == rg_q.stk)
    else $error("stack read address wrong");
  move_dest_a: assert property (st_q == S_BWR && is_move(cmd_q.op)
    |-> mem_wr_o && mem_addr_o == rg_q.tgt)
    else $error("move destination wrong");
  repeat_in_a: assert property (st_q == S_BWR && mem_ack_i && !is_move(cmd_q.op)
    && is_rep(cmd_q.op) && rg_q.cnt[15:8] != 8'h01 |=> st_q == S_IOR)
    else $error("input repeat stopped");
  repeat_mv_a: assert property (st_q == S_BWR && mem_ack_i && is_rep(cmd_q.op)
    && is_move(cmd_q.op) && rg_q.cnt == 16'h0001 |=> st_q == S_IDLE)
    else $error("move repeat overran");
  branch_nz_a: assert property (take && cmd_i.op == xbo_pkg::OP_ABS_BRANCH
    && cmd_i.cond_en && cmd_i.cond == xbo_pkg::COND_NONZERO
    && rg_q.flg[xbo_pkg::FLAG_ZERO_POS] |=> pcnt_o == $past(rg_q.pcnt)
    + 16'($past(cmd_i.len))) else $error("branch taken on zero");
  neg_acc_a: assert property (take && cmd_i.op == xbo_pkg::OP_TWOS_COMPLEMENT
    |=> acc_o + $past(acc_o) == 8'h00) else $error("negate wrong");
endmodule

// ---- xbo_mem_model.sv ----
// Memory and port space model on the far side of the executor bus
`timescale 1ns/1ps
module xbo_mem_model (
  input  wire logic        clk_i,   // System clock
  input  wire logic        rst_i,   // Sync reset, high
  input  wire logic        slow_i,  // Insert wait cycles when high
  input  wire logic        req_i,   // Bus request
  input  wire logic        wr_i,    // Write when high
  input  wire logic        io_i,    // Port space when high
  input  wire logic [15:0] addr_i,  // Bus address
  input  wire logic [7:0]  wdata_i, // Write data
  output logic             ack_o,   // One-cycle completion
  output logic [7:0]       rdata_o  // Read data on ack
);
  logic [7:0] mem [0:65535];
  logic [1:0] wait_q;
  logic [7:0] data_q;

  // Off the ack cycle the bus shows garbage, never the stale byte
  assign rdata_o = ack_o ? data_q : ~data_q;

  always @(posedge clk_i) begin
    if (rst_i || ack_o) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      if (ack_o && wr_i && !io_i)
        mem[addr_i] <= wdata_i;
    end else if (req_i && (!slow_i || wait_q == 2'h3)) begin
      ack_o <= 1'b1;
      // Port data is the low address byte, scrambled
      data_q <= io_i ? addr_i[7:0] ^ 8'h3c : mem[addr_i];
    end else if (req_i) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// ---- xbo_tb.sv ----
// Self-checking bench for the exchange, block and branch executor
`timescale 1ns/1ps
module testbench;
  logic                 sys_clk, sys_rst, cmd_valid, cmd_ready, irq, slow;
  logic                 mem_req, mem_wr, mem_io, mem_ack, halted;
  logic [15:0]          mem_addr, pcnt, pc;
  logic [7:0]           mem_wdata, mem_rdata, acc;
  logic [1:0]           imode;
  xbo_pkg::xbo_cmd_type cmd;
  int                   mismatches, checks_done;

  always #25 sys_clk = ~sys_clk;

  xbo_exec u_xbo_exec (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_ready),
    .irq_i(irq), .mem_req_o(mem_req), .mem_wr_o(mem_wr), .mem_io_o(mem_io),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack),
    .mem_rdata_i(mem_rdata), .halted_o(halted), .pcnt_o(pcnt),
    .acc_o(acc), .imode_o(imode));
  xbo_mem_model u_xbo_mem_model (.clk_i(sys_clk), .rst_i(sys_rst),
    .slow_i(slow), .req_i(mem_req), .wr_i(mem_wr), .io_i(mem_io),
    .addr_i(mem_addr), .wdata_i(mem_wdata), .ack_o(mem_ack),
    .rdata_o(mem_rdata));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk("cmd_ready", 16'h0001, 16'(cmd_ready));
  endtask

  // Offers one op at a falling edge; done low skips the completion wait
  task automatic exe(xbo_pkg::xbo_op_type op, logic [15:0] imm = 16'h0000,
                     logic [1:0] pr = xbo_pkg::PAIR_MEMPTR,
                     logic [2:0] cc = 3'h0, bit done = 1'b1);
    wait_ready();
    cmd = '{op: op, rsel: xbo_pkg::RSEL_ACC, pair: pr,
            ss: xbo_pkg::SS_MEMPTR, cond_en: cc[2], cond: cc[1:0],
            len: 2'h1, imm: imm};
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    pc = pc + 16'h0001;
    if (done)
      wait_ready();
  endtask

  function automatic logic [15:0] word(logic [15:0] a);
    return {u_xbo_mem_model.mem[a + 16'h0001], u_xbo_mem_model.mem[a]};
  endfunction

  task automatic poke(logic [15:0] a, logic [15:0] w);
    {u_xbo_mem_model.mem[a + 16'h0001], u_xbo_mem_model.mem[a]} = w;
  endtask

  // Pairs are only visible by storing them out to memory
  task automatic pair_is(logic [1:0] pr, logic [15:0] exp);
    exe(xbo_pkg::OP_ST_PAIR_MEM, 16'h0300, pr);
    chk("stored pair", exp, word(16'h0300));
  endtask

  task automatic t_regs();
    for (int m = 2; m >= 0; m--) begin
      exe(xbo_pkg::xbo_op_type'(int'(xbo_pkg::OP_MODE0) + m));
      chk("imode", 16'(m), 16'(imode));
    end
    exe(xbo_pkg::OP_IN_IMM, 16'h0091);
    chk("acc", 16'h00ad, 16'(acc));
    exe(xbo_pkg::OP_TWOS_COMPLEMENT);
    chk("acc", 16'h0053, 16'(acc));
    exe(xbo_pkg::OP_LD_IVEC_ACC);
    exe(xbo_pkg::OP_TWOS_COMPLEMENT);
    exe(xbo_pkg::OP_IDLE);
    chk("acc", 16'h00ad, 16'(acc));
    exe(xbo_pkg::OP_LD_ACC_IVEC);
    chk("acc", 16'h0053, 16'(acc));
    exe(xbo_pkg::OP_SWAP_ACCF);
    chk("acc", 16'h0000, 16'(acc));
    exe(xbo_pkg::OP_SWAP_ACCF);
    chk("acc", 16'h0053, 16'(acc));
    chk("pcnt", pc, pcnt);
  endtask

  task automatic t_block();
    poke(16'h0100, 16'h1000);
    poke(16'h0102, 16'h2000);
    poke(16'h0104, 16'h0003);
    poke(16'h1000, 16'h2211);
    poke(16'h1002, 16'h4433);
    poke(16'h2002, 16'h0000);
    for (int p = 0; p < 3; p++)
      exe(xbo_pkg::OP_LD_PAIR_MEM, 16'h0100 + 16'(2 * p), 2'(2 - p));
    slow = 1'b1;
    exe(xbo_pkg::OP_MOVE_UP_REPEAT);
    slow = 1'b0;
    chk("moved", 16'h2211, word(16'h2000));
    chk("moved", 16'h0033, word(16'h2002));
    pair_is(xbo_pkg::PAIR_MEMPTR, 16'h1003);
    pair_is(xbo_pkg::PAIR_COUNTER, 16'h0000);
    exe(xbo_pkg::OP_MOVE_DOWN_STEP);
    chk("moved", 16'h0044, 16'(u_xbo_mem_model.mem[16'h2003]));
    pair_is(xbo_pkg::PAIR_TARGET, 16'h2002);
    pair_is(xbo_pkg::PAIR_COUNTER, 16'hffff);
    poke(16'h0104, 16'h0244);
    poke(16'h1004, 16'h0000);
    exe(xbo_pkg::OP_LD_PAIR_MEM, 16'h0104, xbo_pkg::PAIR_COUNTER);
    exe(xbo_pkg::OP_BIN_UP_REPEAT);
    chk("input", 16'h7878, word(16'h1002));
    chk("input", 16'h0000, word(16'h1004));
    pair_is(xbo_pkg::PAIR_COUNTER, 16'h0044);
    exe(xbo_pkg::OP_BIN_DOWN_STEP);
    chk("input", 16'h0078, word(16'h1004));
    pair_is(xbo_pkg::PAIR_MEMPTR, 16'h1003);
    exe(xbo_pkg::OP_IN_REG);
    chk("acc", 16'h0078, 16'(acc));
  endtask

  task automatic t_swap();
    exe(xbo_pkg::OP_SWAP_TGT_MPTR);
    pair_is(xbo_pkg::PAIR_TARGET, 16'h1003);
    pair_is(xbo_pkg::PAIR_MEMPTR, 16'h2002);
    exe(xbo_pkg::OP_SWAP_ALL);
    pair_is(xbo_pkg::PAIR_COUNTER, 16'h0000);
    exe(xbo_pkg::OP_SWAP_ALL);
    pair_is(xbo_pkg::PAIR_COUNTER, 16'hff44);
    exe(xbo_pkg::OP_LD_STK_SS);
    poke(16'h2002, 16'hbeef);
    exe(xbo_pkg::OP_SWAP_STACK);
    pair_is(xbo_pkg::PAIR_MEMPTR, 16'hbeef);
    chk("stack word", 16'h2002, word(16'h2002));
  endtask

  // Flags stay clear throughout, so only the odd condition codes fail
  task automatic t_branch();
    exe(xbo_pkg::OP_ABS_BRANCH, 16'h1234);
    pc = 16'h1234;
    chk("pcnt", pc, pcnt);
    for (int c = 4; c < 8; c++) begin
      exe(xbo_pkg::OP_ABS_BRANCH, 16'h4000, 2'h2, 3'(c));
      if (c % 2 == 0)
        pc = 16'h4000;
      chk("pcnt", pc, pcnt);
      exe(xbo_pkg::OP_REL_BRANCH, 16'h00f0, 2'h2, 3'(c));
      if (c % 2 == 0)
        pc = pc - 16'h0010;
      chk("pcnt", pc, pcnt);
    end
    exe(xbo_pkg::OP_REL_BRANCH, 16'h0005);
    pc = pc + 16'h0005;
    chk("pcnt", pc, pcnt);
    exe(xbo_pkg::OP_ABS_BRANCH_SS);
    pc = 16'hbeef;
    chk("pcnt", pc, pcnt);
  endtask

  task automatic t_halt();
    exe(xbo_pkg::OP_HALT, 16'h0000, 2'h2, 3'h0, 1'b0);
    @(negedge sys_clk);
    cmd.op = xbo_pkg::OP_TWOS_COMPLEMENT;
    cmd_valid = 1'b1;
    repeat (3) @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk("halted", 16'h0001, 16'(halted));
    chk("acc", 16'h0078, 16'(acc));
    chk("pcnt", pc, pcnt);
    irq = 1'b1;
    repeat (5) @(negedge sys_clk);
    irq = 1'b0;
    chk("halted", 16'h0000, 16'(halted));
    exe(xbo_pkg::OP_TWOS_COMPLEMENT);
    chk("acc", 16'h0088, 16'(acc));
  endtask

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    irq = 1'b0;
    slow = 1'b0;
    pc = 16'h0000;
    mismatches = 0;
    checks_done = 0;
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    chk("pcnt", 16'h0000, pcnt);
    chk("imode", 16'h0000, 16'(imode));
    t_regs();
    t_block();
    t_swap();
    t_branch();
    t_halt();
    wrap_up();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end
endmodule
